// ==== rtc_defines.vh ====
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

// Register byte offsets on the APB side.
`define RTC_REG_CMD        8'h00
`define RTC_REG_BUSADDR    8'h04
`define RTC_REG_CLEAR      8'h08
`define RTC_REG_DATA       8'h0C
`define RTC_REG_STATUS     8'h10
`define RTC_REG_SEQ        8'h14

// Sequencer program addresses; remote initialisation is octal 012.
`define RTC_PA_LR_HOLD     8'h00
`define RTC_PA_REMOTE_INIT 8'h0A
`define RTC_PA_RI_HOLD     8'h0B
`define RTC_PA_MEASURE     8'h20
`define RTC_PA_OUTPUT      8'h30

// Bus address bytes.
`define RTC_MY_ADDR        5'h0D
`define RTC_LISTEN_BASE    3'h1
`define RTC_TALK_BASE      3'h2
`define RTC_ADDR_ALL_ONES  5'h1F

// Programming command characters.
`define RTC_CMD_WATT       8'h41
`define RTC_CMD_DBM        8'h44
`define RTC_CMD_TRIG_IMM   8'h54
`define RTC_CMD_TRIG_SET   8'h56
`define RTC_CMD_FREE_RUN   8'h52
`define RTC_CMD_CAL_EN     8'h2B
`define RTC_CMD_CAL_DIS    8'h2D
`define RTC_CMD_RANGE_LO   8'h31
`define RTC_CMD_RANGE_HI   8'h35

// Output mode characters.
`define RTC_MODE_CHAR_WATT 8'h41
`define RTC_MODE_CHAR_DBM  8'h44

// Timing.
`define RTC_CLK_KHZ        10000
`define RTC_SETTLE_MS      1130
`define RTC_IMM_MS         70
`define RTC_FULL_SCALE_PCT 8'h64

// Reset values.
`define RTC_RANGE_RESET    3'h1

`endif

// ==== rtc_ctrl.v ====
// Function
// - Trigger-immediate command releases the active-low measurement hold output.
// - Trigger while remote leaves branch hold loop for remote initialisation.
// - Remote initialisation sits at sequencer address octal 012.
// - After data is taken, wait in remote-init hold loop for next command.
// - Trigger with settling delays first output character by about 1130 ms.
// - Trigger immediate has first character ready within 70 ms.
// - Free run keeps measuring, fresh data every talk cycle while talk addressed.
// - Calibration enable command clears the correction-disable signal.
// - Clear pulse from device clear sets the correction-disable signal.
// - Disabled correction is treated as exactly 100 percent, readings unscaled.
// - Device clear returns sequencer to hold loop without starting a measurement.
// - Commands after a foreign listen address are ignored once unaddressed.
// - Watt mode is reported with mode character A in the output data.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.vh"

module rtc_fifo #(
  parameter W = 16,
  parameter D = 32
) (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   in_valid,
  output wire                   in_ready,
  input  wire [W-1:0]           in_data,
  output wire                   out_valid,
  input  wire                   out_ready,
  output wire [W-1:0]           out_data,
  output wire [$clog2(D):0]     count
);
  // The extra pointer bit tells a full queue from an empty one.
  localparam AW = $clog2(D);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW:0]  wptr;
  reg  [AW:0]  rptr;
  wire         push;
  wire         pop;

  assign count     = wptr - rptr;
  assign in_ready  = (count != D[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge pclk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= {(AW+1){1'b0}};
      rptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule

module rtc_ctrl #(
  parameter SETTLE_CYC = `RTC_SETTLE_MS * `RTC_CLK_KHZ,
  parameter IMM_CYC    = `RTC_IMM_MS * `RTC_CLK_KHZ,
  parameter DEPTH      = 32
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [15:0] meas_value,
  input  wire [7:0]  cal_switch_pct,
  output reg         hold_n,
  output reg         correction_disable,
  output reg  [7:0]  seq_addr
);
  localparam S_LR_HOLD = 3'h0;
  localparam S_RINIT   = 3'h1;
  localparam S_MEASURE = 3'h2;
  localparam S_OUT0    = 3'h3;
  localparam S_OUT1    = 3'h4;
  localparam S_RI_HOLD = 3'h5;

  reg  [2:0]  state;
  // A 24-bit timer caps the settle count near 1.68 s at the 10 MHz clock.
  reg  [23:0] timer;
  reg         listen;
  reg         talk;
  reg         remote;
  reg         cmd_valid;
  reg  [7:0]  cmd_char;
  reg         clear_pulse;
  reg         watt;
  reg  [2:0]  range;
  reg         free_run;
  reg         settle;
  reg  [15:0] result;
  reg         rd_pop;
  reg  [15:0] push_data;
  reg         push_valid;
  wire        push_ready;
  wire        fifo_valid;
  wire [15:0] fifo_data;
  wire [$clog2(DEPTH):0] fifo_count;
  wire        setup;
  wire        access;
  wire        mapped;
  wire        cmd_take;

  assign setup    = psel && !penable;
  assign access   = psel && penable && pready;
  assign mapped   = (paddr == `RTC_REG_CMD) || (paddr == `RTC_REG_BUSADDR) ||
                    (paddr == `RTC_REG_CLEAR) || (paddr == `RTC_REG_DATA) ||
                    (paddr == `RTC_REG_STATUS) || (paddr == `RTC_REG_SEQ);
  // Commands wait in cmd_valid while the program is busy; only the hold loops take them.
  assign cmd_take = cmd_valid && (state == S_LR_HOLD || state == S_RI_HOLD);

  // Disabled correction skips the divide and returns the raw value, as if the switch read exactly 100.
  function [15:0] rtc_scale;
    input [15:0] raw;
    input [7:0]  pct;
    input        dis;
    reg   [23:0] prod;
    reg   [23:0] quot;
    begin
      prod = raw * `RTC_FULL_SCALE_PCT;
      quot = 24'h000000;
      if (dis || pct == 8'h00) begin
        rtc_scale = raw;
      end else begin
        quot      = prod / {16'h0000, pct};
        rtc_scale = quot[15:0];
      end
    end
  endfunction

  function [7:0] rtc_pa;
    input [2:0] st;
    begin
      case (st)
        S_LR_HOLD: rtc_pa = `RTC_PA_LR_HOLD;
        S_RINIT:   rtc_pa = `RTC_PA_REMOTE_INIT;
        S_MEASURE: rtc_pa = `RTC_PA_MEASURE;
        S_OUT0:    rtc_pa = `RTC_PA_OUTPUT;
        S_OUT1:    rtc_pa = `RTC_PA_OUTPUT;
        S_RI_HOLD: rtc_pa = `RTC_PA_RI_HOLD;
        default:   rtc_pa = `RTC_PA_LR_HOLD;
      endcase
    end
  endfunction

  // A write counts only at the access edge, so a setup cycle never acts on its own.
  function rtc_wr_hit;
    input       acc;
    input       wr;
    input [7:0] a;
    input [7:0] off;
    begin
      rtc_wr_hit = acc && wr && (a == off);
    end
  endfunction

  rtc_fifo #(
    .W (16),
    .D (DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (access && !pwrite && rd_pop),
    .out_data  (fifo_data),
    .count     (fifo_count)
  );

  // APB slave: one wait-free access phase, read data latched in the setup cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      rd_pop  <= 1'b0;
    end else begin
      pready  <= setup;
      // Unmapped addresses still complete in one access cycle, flagged by an error.
      pslverr <= setup && !mapped;
      // The pop is armed in setup so that a read of an empty queue never moves the pointer.
      rd_pop  <= setup && !pwrite && (paddr == `RTC_REG_DATA) && fifo_valid;
      if (setup && !pwrite) begin
        case (paddr)
          `RTC_REG_CMD:     prdata <= {24'h000000, cmd_char};
          `RTC_REG_DATA:    prdata <= fifo_valid ? {16'h0000, fifo_data} : 32'h00000000;
          `RTC_REG_STATUS:  prdata <= {fifo_count[5:0], 11'h000, state, range, settle, free_run,
                                       watt, correction_disable, hold_n, remote, talk, listen, 1'b0};
          `RTC_REG_SEQ:     prdata <= {24'h000000, seq_addr};
          default:          prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Bus addressing, command capture and clear generation.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      listen      <= 1'b0;
      talk        <= 1'b0;
      remote      <= 1'b0;
      cmd_valid   <= 1'b0;
      cmd_char    <= 8'h00;
      clear_pulse <= 1'b0;
    end else begin
      clear_pulse <= rtc_wr_hit(access, pwrite, paddr, `RTC_REG_CLEAR);
      if (rtc_wr_hit(access, pwrite, paddr, `RTC_REG_BUSADDR)) begin
        if (pwdata[7:5] == `RTC_LISTEN_BASE) begin
          // A foreign listen address or unlisten drops listen.
          listen <= (pwdata[4:0] == `RTC_MY_ADDR);
          if (pwdata[4:0] == `RTC_MY_ADDR) begin
            remote <= 1'b1;
          end
        end else if (pwdata[7:5] == `RTC_TALK_BASE) begin
          talk <= (pwdata[4:0] == `RTC_MY_ADDR);
        end
      end
      // A fresh command wins over the consume of an older one.
      if (rtc_wr_hit(access, pwrite, paddr, `RTC_REG_CMD) && listen) begin
        cmd_valid <= 1'b1;
        cmd_char  <= pwdata[7:0];
      end else if (cmd_take || clear_pulse) begin
        cmd_valid <= 1'b0;
      end
    end
  end

  // Measurement program sequencer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state              <= S_LR_HOLD;
      seq_addr           <= `RTC_PA_LR_HOLD;
      timer              <= 24'h000000;
      hold_n             <= 1'b0;
      correction_disable <= 1'b1;
      watt               <= 1'b1;
      range              <= `RTC_RANGE_RESET;
      free_run           <= 1'b0;
      settle             <= 1'b0;
      result             <= 16'h0000;
      push_valid         <= 1'b0;
      push_data          <= 16'h0000;
    end else if (clear_pulse) begin
      // Clear parks the program without a measurement, so the display holds.
      correction_disable <= 1'b1;
      state              <= S_LR_HOLD;
      seq_addr           <= `RTC_PA_LR_HOLD;
      hold_n             <= 1'b0;
      free_run           <= 1'b0;
      push_valid         <= 1'b0;
    end else begin
      // The program address trails the state by one cycle, as a sequencer latch would.
      seq_addr <= rtc_pa(state);
      case (state)
        S_LR_HOLD, S_RI_HOLD: begin
          if (cmd_take) begin
            if (cmd_char == `RTC_CMD_WATT) begin
              watt <= 1'b1;
            end else if (cmd_char == `RTC_CMD_DBM) begin
              watt <= 1'b0;
            end else if (cmd_char >= `RTC_CMD_RANGE_LO && cmd_char <= `RTC_CMD_RANGE_HI) begin
              range <= cmd_char[2:0];
            end else if (cmd_char == `RTC_CMD_CAL_EN) begin
              correction_disable <= 1'b0;
            end else if (cmd_char == `RTC_CMD_CAL_DIS) begin
              correction_disable <= 1'b1;
            end else if (cmd_char == `RTC_CMD_TRIG_IMM || cmd_char == `RTC_CMD_TRIG_SET ||
                         cmd_char == `RTC_CMD_FREE_RUN) begin
              hold_n   <= 1'b1;
              settle   <= (cmd_char == `RTC_CMD_TRIG_SET);
              free_run <= (cmd_char == `RTC_CMD_FREE_RUN);
              if (remote) begin
                state <= S_RINIT;
              end
            end
          end else if (state == S_RI_HOLD && free_run && talk && !fifo_valid) begin
            // Free run starts the next reading as soon as the last one is taken.
            timer <= 24'h000000;
            state <= S_MEASURE;
          end
        end
        S_RINIT: begin
          timer <= 24'h000000;
          state <= S_MEASURE;
        end
        S_MEASURE: begin
          timer <= timer + 24'h000001;
          // Settling delays the first character; immediate stays inside its bound.
          if ((settle && timer >= SETTLE_CYC - 1) || (!settle && timer >= IMM_CYC - 1)) begin
            result <= rtc_scale(meas_value, cal_switch_pct, correction_disable);
            state  <= S_OUT0;
          end
        end
        S_OUT0: begin
          if (push_valid && push_ready) begin
            push_valid <= 1'b0;
            state      <= S_OUT1;
          end else begin
            push_valid <= 1'b1;
            push_data  <= {8'h00, watt ? `RTC_MODE_CHAR_WATT : `RTC_MODE_CHAR_DBM};
          end
        end
        S_OUT1: begin
          if (push_valid && push_ready) begin
            push_valid <= 1'b0;
            // In free run the hold stays released so the meter keeps measuring.
            hold_n     <= free_run;
            state      <= S_RI_HOLD;
          end else begin
            push_valid <= 1'b1;
            push_data  <= result;
          end
        end
        default: begin
          state <= S_LR_HOLD;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// ==== rtc_ctrl_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.vh"
module rtc_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        hold_n,
  input wire logic        correction_disable,
  input wire logic [7:0]  seq_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       wr  = psel && penable && pready && pwrite;
  wire       wc  = wr && paddr == `RTC_REG_CMD;
  wire [7:0] ch  = pwdata[7:0];
  wire       clr = wr && paddr == `RTC_REG_CLEAR;
  wire       trg = wc && (ch == `RTC_CMD_TRIG_IMM || ch == `RTC_CMD_TRIG_SET || ch == `RTC_CMD_FREE_RUN);
  // Short histories let effects land a few cycles after the write that caused them.
  logic [3:0] trg_sh, cal_sh, off_sh, any_sh;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trg_sh <= 4'h0;
      cal_sh <= 4'h0;
      off_sh <= 4'h0;
      any_sh <= 4'h0;
    end else begin
      trg_sh <= {trg_sh[2:0], trg};
      cal_sh <= {cal_sh[2:0], wc && ch == `RTC_CMD_CAL_EN};
      off_sh <= {off_sh[2:0], clr || (wc && ch == `RTC_CMD_CAL_DIS)};
      any_sh <= {any_sh[2:0], wc || clr};
    end
  end
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc)
    else $error("pready outside access phase");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("pslverr without pready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one)
    else $error("pready longer than one cycle");
  property p_rel; $rose(hold_n) |-> |trg_sh; endproperty
  a_rel: assert property (p_rel)
    else $error("hold released without trigger");
  property p_ri; trg |-> ##[2:5] seq_addr == `RTC_PA_REMOTE_INIT; endproperty
  a_ri: assert property (p_ri)
    else $error("trigger did not reach remote init");
  property p_wait; seq_addr == `RTC_PA_RI_HOLD && !hold_n |=> seq_addr == `RTC_PA_RI_HOLD || |any_sh; endproperty
  a_wait: assert property (p_wait)
    else $error("left hold loop without command");
  property p_en; $fell(correction_disable) |-> |cal_sh; endproperty
  a_en: assert property (p_en)
    else $error("correction enabled without command");
  property p_off; $rose(correction_disable) |-> |off_sh; endproperty
  a_off: assert property (p_off)
    else $error("correction disabled without cause");
  property p_clr; clr |-> ##[2:5] (correction_disable && !hold_n && seq_addr == `RTC_PA_LR_HOLD); endproperty
  a_clr: assert property (p_clr)
    else $error("device clear did not park sequencer");
endmodule
bind rtc_ctrl rtc_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .hold_n, .correction_disable, .seq_addr);
`default_nettype wire

// ==== rtc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_host (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // One bus controller transfer; the request is held until pready is sampled high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      tb.errors++;
      tb.wrap_up();
    end else begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.vh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hold_n, correction_disable;
  logic [7:0]  paddr, cal_switch_pct, seq_addr;
  logic [31:0] pwdata, prdata, q;
  logic        e;
  logic [15:0] meas_value;
  int          errors, checks_done;
  localparam int IMM = 10;
  localparam logic [7:0] CMD = `RTC_REG_CMD, STS = `RTC_REG_STATUS, DAT = `RTC_REG_DATA;
  rtc_ctrl #(.SETTLE_CYC(40), .IMM_CYC(IMM), .DEPTH(32)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .meas_value, .cal_switch_pct, .hold_n, .correction_disable,
    .seq_addr);
  rtc_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic wrap_up();
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, {24'h000000, d}, q, e);
  endtask
  task automatic pop(input logic [15:0] x);
    u_host.xfer(1'b0, DAT, 32'h00000000, q, e);
    chk("data", {16'h0000, x}, q);
  endtask
  task automatic cnt(input logic [5:0] n);
    u_host.xfer(1'b0, STS, 32'h00000000, q, e);
    chk("count", {26'h0, n}, {26'h0, q[31:26]});
  endtask
  // Waits for n queued words with the sequencer parked in its hold loop.
  task automatic wt(input logic [5:0] n);
    for (int i = 0; i < 300; i++) begin
      u_host.xfer(1'b0, STS, 32'h00000000, q, e);
      if (q[31:26] === n && seq_addr === `RTC_PA_RI_HOLD)
        return;
    end
    errors++;
    wrap_up();
  endtask
  task automatic t_base();
    chk("reset", 32'h00000100, {22'h0, hold_n, correction_disable, seq_addr});
    u_host.xfer(1'b0, 8'h18, 32'h00000000, q, e);
    chk("slverr", 32'h00000001, {31'h0, e});
    wr(`RTC_REG_BUSADDR, 8'h2D);
    wr(CMD, `RTC_CMD_WATT);
    wr(`RTC_REG_BUSADDR, 8'h3F);
    wr(`RTC_REG_BUSADDR, 8'h25);
    wr(CMD, `RTC_CMD_DBM);
    u_host.xfer(1'b0, STS, 32'h00000000, q, e);
    chk("watt", 32'h00000001, {31'h0, q[6]});
    wr(`RTC_REG_BUSADDR, 8'h2D);
    wr(CMD, `RTC_CMD_DBM);
    wr(CMD, `RTC_CMD_RANGE_LO + 8'h01);
    u_host.xfer(1'b0, STS, 32'h00000000, q, e);
    chk("dbm", 32'h00000000, {31'h0, q[6]});
    chk("range", 32'h00000002, {29'h0, q[11:9]});
    wr(CMD, `RTC_CMD_WATT);
  endtask
  task automatic t_imm();
    logic seen;
    seen = 1'b0;
    wr(CMD, `RTC_CMD_TRIG_IMM);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      seen |= (seq_addr === `RTC_PA_REMOTE_INIT);
    end
    chk("hold_n", 32'h00000001, {31'h0, hold_n});
    chk("ri_seen", 32'h00000001, {31'h0, seen});
    repeat (IMM) @(posedge pclk);
    cnt(6'h02);
    pop(16'h0041);
    pop(16'h0123);
    repeat (20) @(posedge pclk);
    chk("ri_hold", 32'h0000000B, {23'h0, hold_n, seq_addr});
  endtask
  task automatic t_cal();
    wr(CMD, `RTC_CMD_TRIG_SET);
    repeat (IMM + 8) @(posedge pclk);
    cnt(6'h00);
    wt(6'h02);
    pop(16'h0041);
    pop(16'h0123);
    wr(CMD, `RTC_CMD_CAL_EN);
    meas_value <= 16'h0100;
    wr(CMD, `RTC_CMD_TRIG_IMM);
    chk("corr", 32'h00000000, {31'h0, correction_disable});
    wt(6'h02);
    pop(16'h0041);
    pop(16'h0140);
    wr(CMD, `RTC_CMD_CAL_DIS);
    repeat (2) @(posedge pclk);
    chk("corr_off", 32'h00000001, {31'h0, correction_disable});
    wr(CMD, `RTC_CMD_CAL_EN);
    wr(`RTC_REG_CLEAR, 8'h00);
    repeat (4) @(posedge pclk);
    chk("clear", 32'h00000100, {22'h0, hold_n, correction_disable, seq_addr});
    repeat (IMM + 8) @(posedge pclk);
    cnt(6'h00);
    wr(CMD, `RTC_CMD_TRIG_IMM);
    wt(6'h02);
    pop(16'h0041);
    pop(16'h0100);
  endtask
  task automatic t_free();
    meas_value <= 16'h0200;
    wr(`RTC_REG_BUSADDR, 8'h4D);
    wr(CMD, `RTC_CMD_FREE_RUN);
    for (int k = 0; k < 3; k++) begin
      wt(6'h02);
      chk("free_hold", 32'h00000001, {31'h0, hold_n});
      pop(16'h0041);
      pop(16'h0200 + k[15:0]);
      meas_value <= 16'h0201 + k[15:0];
    end
    wr(`RTC_REG_BUSADDR, 8'h5F);
    wr(`RTC_REG_CLEAR, 8'h00);
    for (int i = 0; i < 3; i++)
      u_host.xfer(1'b0, DAT, 32'h00000000, q, e);
  endtask
  // The bench never reads the data register while the queue fills, so the sequencer must stall when full.
  task automatic t_fifo();
    for (int i = 1; i <= 16; i++) begin
      wr(CMD, `RTC_CMD_TRIG_IMM);
      wt(6'(2 * i));
    end
    wr(CMD, `RTC_CMD_TRIG_IMM);
    repeat (IMM + 10) @(posedge pclk);
    cnt(6'h20);
    for (int i = 0; i < 34; i++)
      pop(i[0] ? meas_value : 16'h0041);
    pop(16'h0000);
    cnt(6'h00);
  endtask
  initial begin
    presetn = 1'b0;
    meas_value = 16'h0123;
    cal_switch_pct = 8'h50;
    errors = 0;
    checks_done = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_base();
    t_imm();
    t_cal();
    t_free();
    t_fifo();
    wrap_up();
  end
endmodule
`default_nettype wire
